//--- bsd_sub_exec.sv
// Decode and execute of the general and address subtract instructions
`timescale 1ns/1ps
module bsd_sub_exec (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // Instruction issue
  input wire logic INSTR_VALID_IN,
  input wire logic [15:0] INSTR_WORD_IN,
  // Operands from register file and operand fetch
  output bsd_pkg::bsd_sel_t REG_SEL_OUT,
  input wire logic [31:0] REG_OPERAND_IN,
  input wire logic [31:0] EA_OPERAND_IN,
  // Results
  output logic DONE_OUT,
  output logic ILLEGAL_OUT,
  output logic REG_WR_OUT,
  output bsd_pkg::bsd_wr_t REG_WR_DATA_OUT,
  output logic EA_WR_OUT,
  output bsd_pkg::bsd_wr_t EA_WR_DATA_OUT,
  output logic [4:0] CCR_OUT
);

  // ****************************************
  // Field extraction
  // ****************************************
  logic is_sub_line;
  logic [2:0] reg_f;
  logic [2:0] opm;
  logic [2:0] eam;
  logic [2:0] ear;

  assign is_sub_line = INSTR_WORD_IN[bsd_pkg::LINE_HI:bsd_pkg::LINE_LO] == bsd_pkg::LINE_SUB;
  assign reg_f = INSTR_WORD_IN[bsd_pkg::REG_HI:bsd_pkg::REG_LO];
  assign opm = INSTR_WORD_IN[bsd_pkg::OPM_HI:bsd_pkg::OPM_LO];
  assign eam = INSTR_WORD_IN[bsd_pkg::EAM_HI:bsd_pkg::EAM_LO];
  assign ear = INSTR_WORD_IN[bsd_pkg::EAR_HI:bsd_pkg::EAR_LO];

  // ****************************************
  // Operation decode
  // ****************************************
  bsd_pkg::bsd_kind_t kind;
  bsd_pkg::bsd_size_t size;

  always_comb begin
    kind = bsd_pkg::OPK_NONE;
    size = bsd_pkg::SZ_LONG;
    if (is_sub_line) begin
      if (opm == bsd_pkg::OPM_ADDR_WORD || opm == bsd_pkg::OPM_ADDR_LONG) begin
        kind = bsd_pkg::OPK_ADDR;
        size = (opm == bsd_pkg::OPM_ADDR_WORD) ? bsd_pkg::SZ_WORD : bsd_pkg::SZ_LONG;
      end else begin
        kind = opm[2] ? bsd_pkg::OPK_TO_EA : bsd_pkg::OPK_TO_DREG;
        unique case (opm[1:0])
          2'h0: size = bsd_pkg::SZ_BYTE;
          2'h1: size = bsd_pkg::SZ_WORD;
          default: size = bsd_pkg::SZ_LONG;
        endcase
      end
    end
  end

  // ****************************************
  // Addressing mode legality
  // ****************************************
  logic special_src_ok;
  logic src_ok;
  logic dst_ok;
  logic legal;

  // Mode 111 decodes absolute, PC-relative and immediate; other register codes are unused
  assign special_src_ok = ear == bsd_pkg::EAR_ABS_SHORT || ear == bsd_pkg::EAR_ABS_LONG ||
                          ear == bsd_pkg::EAR_PC_DISP || ear == bsd_pkg::EAR_PC_INDEX ||
                          ear == bsd_pkg::EAR_IMMEDIATE;

  always_comb begin
    src_ok = 1'b1;
    if (eam == bsd_pkg::EAM_SPECIAL) begin
      src_ok = special_src_ok;
    end else if (eam == bsd_pkg::EAM_AREG && size == bsd_pkg::SZ_BYTE) begin
      src_ok = 1'b0;
    end
  end

  // Register direct, immediate and PC-relative cannot be written through the ea field
  always_comb begin
    dst_ok = 1'b1;
    if (eam == bsd_pkg::EAM_DREG || eam == bsd_pkg::EAM_AREG) begin
      dst_ok = 1'b0;
    end else if (eam == bsd_pkg::EAM_SPECIAL) begin
      dst_ok = ear == bsd_pkg::EAR_ABS_SHORT || ear == bsd_pkg::EAR_ABS_LONG;
    end
  end

  always_comb begin
    unique case (kind)
      bsd_pkg::OPK_TO_DREG: legal = src_ok;
      bsd_pkg::OPK_TO_EA: legal = dst_ok;
      bsd_pkg::OPK_ADDR: legal = src_ok;
      default: legal = 1'b0;
    endcase
  end

  // ****************************************
  // Operand selection
  // ****************************************
  logic [31:0] op_dst;
  logic [31:0] op_src;

  // Register field names a data register, or an address register for the address form
  assign REG_SEL_OUT = '{is_addr: kind == bsd_pkg::OPK_ADDR, idx: reg_f};

  always_comb begin
    op_dst = REG_OPERAND_IN;
    op_src = EA_OPERAND_IN;
    if (kind == bsd_pkg::OPK_TO_EA) begin
      op_dst = EA_OPERAND_IN;
      op_src = REG_OPERAND_IN;
    end else if (kind == bsd_pkg::OPK_ADDR && size == bsd_pkg::SZ_WORD) begin
      op_src = {{16{EA_OPERAND_IN[15]}}, EA_OPERAND_IN[15:0]};
    end
  end

  // ****************************************
  // Subtractor and flags
  // ****************************************
  logic [31:0] diff;
  logic res_n;
  logic res_z;
  logic res_v;
  logic res_c;
  logic dst_msb;
  logic src_msb;

  assign diff = op_dst - op_src;

  always_comb begin
    unique case (size)
      bsd_pkg::SZ_BYTE: begin
        res_c = op_dst[7:0] < op_src[7:0];
        res_z = diff[7:0] == 8'h00;
        res_n = diff[7];
        dst_msb = op_dst[7];
        src_msb = op_src[7];
      end
      bsd_pkg::SZ_WORD: begin
        res_c = op_dst[15:0] < op_src[15:0];
        res_z = diff[15:0] == 16'h0000;
        res_n = diff[15];
        dst_msb = op_dst[15];
        src_msb = op_src[15];
      end
      default: begin
        res_c = op_dst < op_src;
        res_z = diff == 32'h00000000;
        res_n = diff[31];
        dst_msb = op_dst[31];
        src_msb = op_src[31];
      end
    endcase
    res_v = (dst_msb ^ src_msb) & (res_n ^ dst_msb);
  end

  // ****************************************
  // Condition flags
  // ****************************************
  logic general_go;
  logic addr_go;

  assign general_go = INSTR_VALID_IN && legal && kind != bsd_pkg::OPK_ADDR;
  assign addr_go = INSTR_VALID_IN && legal && kind == bsd_pkg::OPK_ADDR;

  // Address form and rejected encodings keep the flags as they were
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      CCR_OUT <= bsd_pkg::CCR_RESET;
    end else if (general_go) begin
      CCR_OUT[bsd_pkg::CC_N] <= res_n;
      CCR_OUT[bsd_pkg::CC_Z] <= res_z;
      CCR_OUT[bsd_pkg::CC_V] <= res_v;
      CCR_OUT[bsd_pkg::CC_C] <= res_c;
      CCR_OUT[bsd_pkg::CC_X] <= res_c;
    end
  end

  // ****************************************
  // Result write-back
  // ****************************************
  logic [31:0] merged;

  // Data register keeps its bits above the operation size
  always_comb begin
    unique case (size)
      bsd_pkg::SZ_BYTE: merged = {REG_OPERAND_IN[31:8], diff[7:0]};
      bsd_pkg::SZ_WORD: merged = {REG_OPERAND_IN[31:16], diff[15:0]};
      default: merged = diff;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      REG_WR_OUT <= 1'b0;
      REG_WR_DATA_OUT <= '0;
    end else begin
      REG_WR_OUT <= addr_go || (general_go && kind == bsd_pkg::OPK_TO_DREG);
      if (addr_go) begin
        REG_WR_DATA_OUT <= '{sel: REG_SEL_OUT, size: bsd_pkg::SZ_LONG, data: diff};
      end else if (general_go) begin
        REG_WR_DATA_OUT <= '{sel: REG_SEL_OUT, size: size, data: merged};
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      EA_WR_OUT <= 1'b0;
      EA_WR_DATA_OUT <= '0;
    end else begin
      EA_WR_OUT <= general_go && kind == bsd_pkg::OPK_TO_EA;
      if (general_go && kind == bsd_pkg::OPK_TO_EA) begin
        EA_WR_DATA_OUT <= '{sel: '{is_addr: 1'b1, idx: ear}, size: size, data: diff};
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      DONE_OUT <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
    end else begin
      DONE_OUT <= general_go || addr_go;
      ILLEGAL_OUT <= INSTR_VALID_IN && is_sub_line && !legal;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] chk_dst;
  logic [31:0] chk_src;
  logic [31:0] out_res;
  bsd_pkg::bsd_size_t out_size;
  logic out_msb;
  logic out_zero;
  logic dst_top;
  logic src_top;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      chk_dst <= 32'h00000000;
      chk_src <= 32'h00000000;
    end else begin
      chk_dst <= op_dst;
      chk_src <= op_src;
    end
  end

  assign out_res = REG_WR_OUT ? REG_WR_DATA_OUT.data : EA_WR_DATA_OUT.data;
  assign out_size = REG_WR_OUT ? REG_WR_DATA_OUT.size : EA_WR_DATA_OUT.size;

  always_comb begin
    unique case (out_size)
      bsd_pkg::SZ_BYTE: begin
        out_msb = out_res[7];
        out_zero = out_res[7:0] == 8'h00;
        dst_top = chk_dst[7];
        src_top = chk_src[7];
      end
      bsd_pkg::SZ_WORD: begin
        out_msb = out_res[15];
        out_zero = out_res[15:0] == 16'h0000;
        dst_top = chk_dst[15];
        src_top = chk_src[15];
      end
      default: begin
        out_msb = out_res[31];
        out_zero = out_res == 32'h00000000;
        dst_top = chk_dst[31];
        src_top = chk_src[31];
      end
    endcase
  end

  default clocking chk_cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  neg_flag_a: assert property (general_go |=> CCR_OUT[bsd_pkg::CC_N] == out_msb)
    else $error("negative flag does not match result sign");
  zero_flag_a: assert property (general_go |=> CCR_OUT[bsd_pkg::CC_Z] == out_zero)
    else $error("zero flag does not match result");
  overflow_flag_a: assert property (general_go |=>
    CCR_OUT[bsd_pkg::CC_V] == ((dst_top != src_top) && (out_msb != dst_top)))
    else $error("overflow flag wrong");
  carry_flag_a: assert property (general_go && size == bsd_pkg::SZ_LONG |=>
    CCR_OUT[bsd_pkg::CC_C] == (chk_dst < chk_src))
    else $error("carry flag does not reflect borrow");
  extend_copy_a: assert property (general_go |=> CCR_OUT[bsd_pkg::CC_X] == CCR_OUT[bsd_pkg::CC_C])
    else $error("extend flag differs from carry");
  dreg_dest_a: assert property (general_go && kind == bsd_pkg::OPK_TO_DREG |=>
    REG_WR_OUT && !EA_WR_OUT && !REG_WR_DATA_OUT.sel.is_addr && REG_WR_DATA_OUT.sel.idx == $past(reg_f))
    else $error("data register destination not written");
  ea_dest_a: assert property (general_go && kind == bsd_pkg::OPK_TO_EA |=>
    EA_WR_OUT && !REG_WR_OUT && EA_WR_DATA_OUT.data == chk_dst - chk_src)
    else $error("ea destination not written");
  byte_areg_a: assert property (INSTR_VALID_IN && kind == bsd_pkg::OPK_TO_DREG &&
    size == bsd_pkg::SZ_BYTE && eam == bsd_pkg::EAM_AREG |=> ILLEGAL_OUT && !REG_WR_OUT && !DONE_OUT && $stable(CCR_OUT))
    else $error("byte source from address register not rejected");
  dst_mode_a: assert property (INSTR_VALID_IN && kind == bsd_pkg::OPK_TO_EA &&
    (eam == bsd_pkg::EAM_DREG || (eam == bsd_pkg::EAM_SPECIAL && ear == bsd_pkg::EAR_IMMEDIATE))
    |=> ILLEGAL_OUT && !EA_WR_OUT && $stable(CCR_OUT))
    else $error("non-alterable destination not rejected");
  src_mode_a: assert property (INSTR_VALID_IN && kind == bsd_pkg::OPK_ADDR &&
    (eam == bsd_pkg::EAM_AREG || (eam == bsd_pkg::EAM_SPECIAL && ear == bsd_pkg::EAR_PC_INDEX))
    |=> !ILLEGAL_OUT && DONE_OUT)
    else $error("legal source mode rejected");
  addr_result_a: assert property (addr_go |=> REG_WR_OUT && REG_WR_DATA_OUT.sel.is_addr &&
    REG_WR_DATA_OUT.sel.idx == $past(reg_f) && REG_WR_DATA_OUT.data == $past(REG_OPERAND_IN) - chk_src)
    else $error("address register result wrong");
  addr_sext_a: assert property (addr_go && size == bsd_pkg::SZ_WORD |=>
    chk_src == {{16{$past(EA_OPERAND_IN[15])}}, $past(EA_OPERAND_IN[15:0])})
    else $error("word source not sign extended");
  addr_flags_a: assert property (addr_go |=> $stable(CCR_OUT))
    else $error("address subtract changed flags");
  carry_sized_a: assert property (general_go && size != bsd_pkg::SZ_LONG |=>
    CCR_OUT[bsd_pkg::CC_C] == ((out_size == bsd_pkg::SZ_BYTE) ? (chk_dst[7:0] < chk_src[7:0]) :
    (chk_dst[15:0] < chk_src[15:0])))
    else $error("carry flag does not reflect sized borrow");
  special_mode_a: assert property (INSTR_VALID_IN && (kind == bsd_pkg::OPK_TO_DREG || kind == bsd_pkg::OPK_ADDR) &&
    eam == bsd_pkg::EAM_SPECIAL && ear > bsd_pkg::EAR_IMMEDIATE |=> ILLEGAL_OUT && !DONE_OUT)
    else $error("unused special mode accepted");
  addr_size_a: assert property (INSTR_VALID_IN && is_sub_line && opm[1:0] == 2'h3 |->
    REG_SEL_OUT.is_addr && size != bsd_pkg::SZ_BYTE)
    else $error("address subtract decoded with byte size");

  to_dreg_c: cover property (general_go && kind == bsd_pkg::OPK_TO_DREG && res_v);
  to_ea_c: cover property (general_go && kind == bsd_pkg::OPK_TO_EA && res_c);
  addr_word_c: cover property (addr_go && size == bsd_pkg::SZ_WORD && EA_OPERAND_IN[15]);
  illegal_c: cover property (INSTR_VALID_IN && is_sub_line && !legal);
  addr_long_c: cover property (addr_go && size == bsd_pkg::SZ_LONG && res_c);

endmodule : bsd_sub_exec

//--- bsd_pkg.sv
// Constants, field layouts and carrier types for the binary subtract decode/execute block
// What this block does
// - General subtract sets N from result sign
// - General subtract sets Z on zero sized result
// - General subtract sets V on signed overflow
// - General subtract sets C on borrow out
// - General subtract copies C into X
// - General subtract register field picks one of eight data registers
// - Source ea accepts every addressing mode except unused mode 111 register codes and byte An
// - Mode 111 register codes map special modes
// - Byte source may not be address register
// - Destination ea only alterable memory modes
// - Data register destination only via register field
// - Address subtract writes result to same register
// - Address subtract is word or long only
// - Mode 011 word sign-extended, 111 long
// - Address subtract leaves all flags unchanged
// - Address subtract register field is address destination
// - Address subtract source accepts every mode except unused mode 111 register codes
package bsd_pkg;

  // ****************************************
  // Instruction word fields
  // ****************************************
  localparam logic [3:0] LINE_SUB = 4'h9;
  localparam int LINE_HI = 15;
  localparam int LINE_LO = 12;
  localparam int REG_HI = 11;
  localparam int REG_LO = 9;
  localparam int OPM_HI = 8;
  localparam int OPM_LO = 6;
  localparam int EAM_HI = 5;
  localparam int EAM_LO = 3;
  localparam int EAR_HI = 2;
  localparam int EAR_LO = 0;

  // ****************************************
  // Operation-mode and effective-address codes
  // ****************************************
  localparam logic [2:0] OPM_ADDR_WORD = 3'h3;
  localparam logic [2:0] OPM_ADDR_LONG = 3'h7;
  localparam logic [2:0] EAM_DREG = 3'h0;
  localparam logic [2:0] EAM_AREG = 3'h1;
  localparam logic [2:0] EAM_SPECIAL = 3'h7;
  localparam logic [2:0] EAR_ABS_SHORT = 3'h0;
  localparam logic [2:0] EAR_ABS_LONG = 3'h1;
  localparam logic [2:0] EAR_PC_DISP = 3'h2;
  localparam logic [2:0] EAR_PC_INDEX = 3'h3;
  localparam logic [2:0] EAR_IMMEDIATE = 3'h4;

  // ****************************************
  // Condition flag positions and reset value
  // ****************************************
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_X = 4;
  localparam logic [4:0] CCR_RESET = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} bsd_size_t;
  typedef enum logic [1:0] {OPK_NONE, OPK_TO_DREG, OPK_TO_EA, OPK_ADDR} bsd_kind_t;

  typedef struct packed {
    logic is_addr;
    logic [2:0] idx;
  } bsd_sel_t;

  typedef struct packed {
    bsd_sel_t sel;
    bsd_size_t size;
    logic [31:0] data;
  } bsd_wr_t;

endpackage : bsd_pkg

//--- bsd_sub_exec_tb.sv
// Self-checking testbench for the subtract decode and execute block
`timescale 1ns/1ps
module bsd_sub_exec_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [31:0] reg_op = 32'h0;
  logic [31:0] ea_op = 32'h0;
  bsd_pkg::bsd_sel_t sel;
  logic done, illegal, reg_wr, ea_wr;
  bsd_pkg::bsd_wr_t reg_data, ea_data;
  logic [4:0] ccr;
  logic [4:0] exp_ccr = 5'h00;
  int error_cnt = 0;
  int comparisons = 0;

  bsd_sub_exec bsd_sub_exec_inst (
    .SYS_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .INSTR_VALID_IN(valid),
    .INSTR_WORD_IN(word),
    .REG_SEL_OUT(sel),
    .REG_OPERAND_IN(reg_op),
    .EA_OPERAND_IN(ea_op),
    .DONE_OUT(done),
    .ILLEGAL_OUT(illegal),
    .REG_WR_OUT(reg_wr),
    .REG_WR_DATA_OUT(reg_data),
    .EA_WR_OUT(ea_wr),
    .EA_WR_DATA_OUT(ea_data),
    .CCR_OUT(ccr)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Compare, drive and reference tasks
  // ****************************************
  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string n, input logic [37:0] e, input logic [37:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_vec

  task automatic drv(input logic v, input logic [15:0] w, input logic [31:0] r, input logic [31:0] e);
    @(posedge clk);
    valid <= v;
    word <= w;
    reg_op <= r;
    ea_op <= e;
  endtask : drv

  // Works out the expected answer to one word and compares every registered output
  task automatic judge(input logic [15:0] w, input logic [31:0] rv, input logic [31:0] ev);
    logic [2:0] opm, m, r;
    logic line, adr, ok;
    logic [1:0] sz;
    logic [31:0] a, b, mask, d;
    int msb;
    opm = w[8:6];
    m = w[5:3];
    r = w[2:0];
    line = (w[15:12] == 4'h9);
    adr = (opm[1:0] == 2'h3);
    sz = adr ? 2'h2 : opm[1:0];
    mask = (sz == 2'h0) ? 32'h0000_00ff : (sz == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
    msb = (8 << sz) - 1;
    if (adr || !opm[2]) ok = !(m == 3'h7 && r > 3'h4) && !(opm == 3'h0 && m == 3'h1);
    else ok = (m > 3'h1 && m < 3'h7) || (m == 3'h7 && r < 3'h2);
    ok = ok && line;
    a = opm[2] ? ev & mask : rv & mask;
    b = opm[2] ? rv & mask : ev & mask;
    d = (a - b) & mask;
    if (adr) d = rv - (opm[2] ? ev : {{16{ev[15]}}, ev[15:0]});
    else if (ok) exp_ccr = {b > a, d[msb], d == 32'h0, (a[msb] != b[msb]) && (d[msb] != a[msb]), b > a};
    chk_bit("done", ok, done);
    chk_bit("illegal", line && !ok, illegal);
    chk_bit("reg_wr", ok && !(opm[2] && !adr), reg_wr);
    chk_bit("ea_wr", ok && opm[2] && !adr, ea_wr);
    if (ok && !(opm[2] && !adr)) begin
      chk_vec("reg_data", {adr, w[11:9], sz, (rv & ~mask) | d}, reg_data);
    end
    if (ok && opm[2] && !adr) begin
      chk_vec("ea_data", {1'b1, r, sz, d}, {ea_data[37:32], ea_data.data & mask});
    end
    chk_vec("ccr", {33'h0, exp_ccr}, {33'h0, ccr});
  endtask : judge

  task automatic run(input logic [15:0] w, input logic [31:0] rv, input logic [31:0] ev);
    drv(1'b1, w, rv, ev);
    #1;
    chk_vec("reg_sel", {34'h0, w[7:6] == 2'h3, w[11:9]}, {34'h0, sel});
    drv(1'b0, w, rv, ev);
    #1;
    judge(w, rv, ev);
    drv(1'b0, w, rv, ev);
    #1;
    chk_bit("done_low", 1'b0, done);
    chk_bit("illegal_low", 1'b0, illegal);
  endtask : run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset(input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk_vec("reset_ccr", 38'h0, {33'h0, ccr});
    chk_vec("reset_reg_data", 38'h0, reg_data);
    chk_vec("reset_ea_data", 38'h0, ea_data);
    chk_bit("reset_done", 1'b0, done);
    chk_bit("reset_wr", 1'b0, reg_wr | ea_wr | illegal);
    @(posedge clk);
    rst_n <= 1'b1;
    exp_ccr = 5'h00;
  endtask : t_reset

  task automatic t_dreg();
    logic [31:0] ev [4] = '{32'h1234_0005, 32'h0000_8000, 32'h8000_0080, 32'h0000_0000};
    logic [31:0] rv [4] = '{32'habcd_0005, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001};
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 4; p++) begin
        run({4'h9, 3'(p * 2 + s), 3'(s), 6'h03}, rv[p], ev[p]);
      end
    end
  endtask : t_dreg

  task automatic t_ea();
    logic [5:0] ea [7] = '{6'h11, 6'h1a, 6'h23, 6'h2c, 6'h35, 6'h38, 6'h39};
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 7; i++) begin
        run({4'h9, 3'h5, 3'(4 + s), ea[i]}, 32'h0000_0010, 32'h0000_0011);
      end
    end
  endtask : t_ea

  task automatic t_dst();
    logic [5:0] ea [5] = '{6'h00, 6'h09, 6'h3a, 6'h3b, 6'h3c};
    for (int s = 4; s < 7; s++) begin
      for (int i = 0; i < 5; i++) begin
        run({4'h9, 3'h2, 3'(s), ea[i]}, 32'h0000_0007, 32'h0000_0002);
      end
    end
  endtask : t_dst

  task automatic t_src();
    logic [5:0] ea;
    for (int i = 0; i < 15; i++) begin
      ea = (i < 7) ? {3'(i), 3'(i)} : {3'h7, 3'(i - 7)};
      run({4'h9, 3'h4, 3'h1, ea}, 32'h0000_0100, 32'h0000_0001);
    end
    run({4'h9, 3'h1, 3'h0, 6'h0a}, 32'h0000_0100, 32'h0000_0001);
    run({4'h9, 3'h1, 3'h2, 6'h0a}, 32'h0000_0100, 32'h0000_0001);
  endtask : t_src

  task automatic t_addr();
    logic [5:0] ea [5] = '{6'h00, 6'h0b, 6'h3c, 6'h3a, 6'h3d};
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 5; i++) begin
        run({4'h9, 3'(i + 3), k ? 3'h7 : 3'h3, ea[i]}, 32'h0001_0000, 32'h1234_8000);
      end
    end
  endtask : t_addr

  task automatic t_b2b();
    drv(1'b1, 16'h9e82, 32'h0000_0003, 32'h0000_0001);
    drv(1'b1, 16'hd040, 32'h0000_0003, 32'h0000_0001);
    #1;
    judge(16'h9e82, 32'h0000_0003, 32'h0000_0001);
    drv(1'b1, 16'h92c9, 32'h8000_0000, 32'h0000_ffff);
    #1;
    judge(16'hd040, 32'h0000_0003, 32'h0000_0001);
    drv(1'b0, 16'h0000, 32'h0, 32'h0);
    #1;
    judge(16'h92c9, 32'h8000_0000, 32'h0000_ffff);
  endtask : t_b2b

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    t_reset(12);
    t_dreg();
    t_ea();
    t_dst();
    t_src();
    t_addr();
    t_b2b();
    t_reset(2);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : bsd_sub_exec_tb
